// file: src/phy_ctrl_pkg.sv
/*
 package for the basic control register block: addresses, bit positions,
 reset values and the soft reset pulse length.
 assumes a single 125 mhz core clock.
*/
package phy_ctrl_pkg;
   localparam int ADDR_W = 5;
   localparam int DATA_W = 16;
   // 32 direct registers: 0h..fh standard, 10h..1fh vendor space
   localparam logic [ADDR_W-1:0] REG_BASIC_CONTROL = 5'h00;
   localparam logic [ADDR_W-1:0] STD_LAST = 5'h0f;
   localparam logic [ADDR_W-1:0] VENDOR_FIRST = 5'h10;
   localparam int BIT_RESET = 15;
   localparam int BIT_LOOPBACK = 14;
   localparam int BIT_SPEED = 13;
   localparam int BIT_AN_EN = 12;
   localparam int BIT_PDOWN = 11;
   localparam int BIT_ISOLATE = 10;
   localparam int BIT_AN_RESTART = 9;
   localparam int BIT_DUPLEX = 8;
   localparam int BIT_COL_TEST = 7;
   localparam logic [DATA_W-1:0] RESERVED_MASK = 16'h007f;
   localparam logic [DATA_W-1:0] ZERO_WORD = 16'h0000;
   // internal reset pulse after a soft reset write
   localparam int RESET_PULSE_NS = 80;
   localparam int CLK_PERIOD_NS = 8;
   localparam int RESET_PULSE_CYC = (RESET_PULSE_NS + CLK_PERIOD_NS - 1)
                                    / CLK_PERIOD_NS;
   localparam logic [3:0] RESET_CNT_ZERO = 4'h0;
   localparam logic [3:0] RESET_CNT_ONE = 4'h1;
   typedef enum logic [1:0] {st_strap, st_run, st_reset} ctrl_state_type;
endpackage

// file: src/phy_reg_if.sv
/*
 carrier between the control register top and the vendor register file.
 assumes both ends share core_clk.
*/
`timescale 1ns/1ps
interface phy_reg_if;
   import phy_ctrl_pkg::*;
   logic wr;
   logic [ADDR_W-1:0] addr;
   logic [DATA_W-1:0] wdata;
   logic [DATA_W-1:0] rdata;
   logic clear;
   modport ctrl (output wr, output addr, output wdata, output clear,
                 input rdata);
   modport bank (input wr, input addr, input wdata, input clear,
                 output rdata);
endinterface

// file: src/phy_vendor_regs.sv
/*
 plain read/write storage for addresses 10h..1fh and the unused standard
 addresses. the top sends all writes, so writes to REG_BASIC_CONTROL are dropped here.
*/
`timescale 1ns/1ps
module phy_vendor_regs
   import phy_ctrl_pkg::*;
(
   // clock and reset
   input wire logic core_clk,
   input wire logic arst_n,
   // register access
   phy_reg_if.bank bus
);
   logic [DATA_W-1:0] mem [2**ADDR_W];
   logic [DATA_W-1:0] next_mem [2**ADDR_W];
   logic [DATA_W-1:0] rd;
   logic [DATA_W-1:0] next_rd;

   ////////////////////////////////////////////////////////////////////
   // next values: a soft reset wipes the vendor space too
   always_comb
   begin
      next_mem = mem;
      if (bus.clear)
      begin
         for (int i = 0; i < 2**ADDR_W; i++)
            next_mem[i] = ZERO_WORD;
      end
      else if (bus.wr && bus.addr != REG_BASIC_CONTROL)
         next_mem[bus.addr] = bus.wdata;
      next_rd = next_mem[bus.addr];
   end

   always_ff @(posedge core_clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         for (int i = 0; i < 2**ADDR_W; i++)
            mem[i] <= ZERO_WORD;
         rd <= ZERO_WORD;
      end
      else
      begin
         mem <= next_mem;
         rd <= next_rd;
      end
   end

   assign bus.rdata = rd;
endmodule

// file: src/phy_basic_control.sv
/*
 basic control register of the phy management space, plus the direct
 32 word register window behind it.
 assumes management frames are decoded elsewhere into a one-cycle write
 strobe and a held read address, synchronous to core_clk.
*/
// How it works
// - thirty-two registers, each reached directly
// - addresses 0h..fh hold the standard layout
// - addresses 10h..1fh hold vendor functions
// - bit 15 writes trigger reset, self-clears
// - bit 14 selects loopback, resets zero
// - bit 13 forces 100 or 10, unless autoneg
// - bit 12 enables autoneg; result overrides forced
// - bit 11 power-down, resets zero
// - in power-down, first reset write wakes only
// - bit 10 isolates mac interface
// - bit 9 restarts autoneg, self-clears
// - bit 8 duplex, default inverse of strap
// - autoneg, isolate, speed defaults from straps
// - bit 7 collision test, resets zero
`timescale 1ns/1ps
module phy_basic_control
   import phy_ctrl_pkg::*;
(
   // clock and reset
   input wire logic core_clk,
   input wire logic arst_n,
   // management access, already decoded from the serial frames
   input wire logic mgmt_wr,
   input wire logic [ADDR_W-1:0] mgmt_addr,
   input wire logic [DATA_W-1:0] mgmt_wdata,
   output logic [DATA_W-1:0] mgmt_rdata,
   // strapping pins
   input wire logic autoneg_enable_strap,
   input wire logic isolate_strap,
   input wire logic speed_strap,
   input wire logic duplex_strap,
   // autoneg result
   input wire logic an_done,
   input wire logic an_speed_100,
   input wire logic an_full_duplex,
   // controls to the phy core
   output logic soft_reset,
   output logic loopback,
   output logic power_down,
   output logic isolate,
   output logic an_enable,
   output logic an_restart,
   output logic speed_100,
   output logic full_duplex,
   output logic col_test
);
   ctrl_state_type state;
   ctrl_state_type next_state;
   logic [DATA_W-1:0] ctrl;
   logic [DATA_W-1:0] next_ctrl;
   logic [3:0] rst_cnt;
   logic [3:0] next_rst_cnt;
   logic an_restart_q;
   logic next_an_restart;
   logic eff_speed;
   logic next_eff_speed;
   logic eff_duplex;
   logic next_eff_duplex;
   logic [DATA_W-1:0] ctrl_rd;
   logic [DATA_W-1:0] next_ctrl_rd;
   logic sel_ctrl;
   logic next_sel_ctrl;
   logic ctrl_wr;
   phy_reg_if regs ();

   ////////////////////////////////////////////////////////////////////
   // all 32 addresses sit in one flat window, no paging
   assign ctrl_wr = mgmt_wr && mgmt_addr == REG_BASIC_CONTROL;
   assign regs.wr = mgmt_wr;
   assign regs.addr = mgmt_addr;
   assign regs.wdata = mgmt_wdata;
   assign regs.clear = state == st_reset;

   // 10h..1fh and unused standard words are plain storage
   phy_vendor_regs vendor_regs (
      .core_clk (core_clk),
      .arst_n (arst_n),
      .bus (regs.bank)
   );

   ////////////////////////////////////////////////////////////////////
   // control register next state; straps load on st_strap only, never
   // under the async reset, so pins are sampled after release
   always_comb
   begin
      next_state = state;
      next_ctrl = ctrl;
      next_rst_cnt = rst_cnt;
      next_an_restart = 1'b0;
      unique case (state)
         st_strap:
         begin
            next_ctrl = ZERO_WORD;
            next_ctrl[BIT_AN_EN] = autoneg_enable_strap;
            next_ctrl[BIT_ISOLATE] = isolate_strap;
            next_ctrl[BIT_SPEED] = speed_strap;
            next_ctrl[BIT_DUPLEX] = ~duplex_strap;
            next_state = st_run;
         end
         st_run:
         begin
            if (ctrl_wr)
            begin
               next_ctrl = mgmt_wdata & ~RESERVED_MASK;
               next_ctrl[BIT_RESET] = 1'b0;
               next_ctrl[BIT_AN_RESTART] = 1'b0;
               next_an_restart = mgmt_wdata[BIT_AN_RESTART];
               if (mgmt_wdata[BIT_RESET])
               begin
                  if (ctrl[BIT_PDOWN])
                  begin
                     // first reset write out of power-down only wakes
                     next_ctrl = ctrl;
                     next_ctrl[BIT_PDOWN] = 1'b0;
                     next_an_restart = 1'b0;
                  end
                  else
                  begin
                     next_state = st_reset;
                     next_rst_cnt = 4'(RESET_PULSE_CYC);
                  end
               end
            end
         end
         st_reset:
         begin
            next_ctrl = ZERO_WORD; // loopback, pdown, col test clear
            if (rst_cnt == RESET_CNT_ONE)
               next_state = st_strap; // re-latch straps
            next_rst_cnt = rst_cnt - RESET_CNT_ONE;
         end
         default:
            next_state = st_strap;
      endcase
   end

   ////////////////////////////////////////////////////////////////////
   // effective speed and duplex: autoneg result wins when enabled and an_done is set
   always_comb
   begin
      next_eff_speed = next_ctrl[BIT_SPEED];
      next_eff_duplex = next_ctrl[BIT_DUPLEX];
      if (next_ctrl[BIT_AN_EN] && an_done)
      begin
         next_eff_speed = an_speed_100;
         next_eff_duplex = an_full_duplex;
      end
      next_sel_ctrl = mgmt_addr == REG_BASIC_CONTROL;
      next_ctrl_rd = next_ctrl & ~RESERVED_MASK;
   end

   always_ff @(posedge core_clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         state <= st_strap;
         ctrl <= ZERO_WORD;
         rst_cnt <= RESET_CNT_ZERO;
         an_restart_q <= 1'b0;
         eff_speed <= 1'b0;
         eff_duplex <= 1'b0;
         ctrl_rd <= ZERO_WORD;
         sel_ctrl <= 1'b0;
      end
      else
      begin
         state <= next_state;
         ctrl <= next_ctrl;
         rst_cnt <= next_rst_cnt;
         an_restart_q <= next_an_restart;
         eff_speed <= next_eff_speed;
         eff_duplex <= next_eff_duplex;
         ctrl_rd <= next_ctrl_rd;
         sel_ctrl <= next_sel_ctrl;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // outputs from flip-flops, except the soft_reset decode of state and the mgmt_rdata mux
   assign mgmt_rdata = sel_ctrl ? ctrl_rd : regs.rdata;
   assign soft_reset = state != st_run;
   assign loopback = ctrl[BIT_LOOPBACK];
   assign power_down = ctrl[BIT_PDOWN];
   assign isolate = ctrl[BIT_ISOLATE];
   assign an_enable = ctrl[BIT_AN_EN];
   assign an_restart = an_restart_q;
   assign speed_100 = eff_speed;
   assign full_duplex = eff_duplex;
   assign col_test = ctrl[BIT_COL_TEST];

   ////////////////////////////////////////////////////////////////////
   // checks
   sequence s_reset_wr;
      state == st_run && ctrl_wr && mgmt_wdata[BIT_RESET]
         && !ctrl[BIT_PDOWN];
   endsequence
   sequence s_wake_wr;
      state == st_run && ctrl_wr && mgmt_wdata[BIT_RESET]
         && ctrl[BIT_PDOWN];
   endsequence

   sequence s_pulse_load;
      state == st_reset && rst_cnt == 4'(RESET_PULSE_CYC)
         && !ctrl[BIT_RESET];
   endsequence
   sequence s_pulse_end;
      state == st_strap ##1 state == st_run && !soft_reset;
   endsequence

   // the pulse length lives in rst_cnt, so each step of the countdown is
   // checked on its own instead of one long repetition
   a_reset_self_clear: assert property (
      @(posedge core_clk) disable iff (!arst_n)
      s_reset_wr |=> soft_reset ##0 s_pulse_load)
      else $error("soft reset pulse did not start");
   a_reset_count: assert property (
      @(posedge core_clk) disable iff (!arst_n)
      state == st_reset && rst_cnt != RESET_CNT_ONE
      |=> state == st_reset && rst_cnt == $past(rst_cnt) - RESET_CNT_ONE)
      else $error("soft reset counter skipped a step");
   a_reset_release: assert property (
      @(posedge core_clk) disable iff (!arst_n)
      state == st_reset && rst_cnt == RESET_CNT_ONE |=> s_pulse_end)
      else $error("soft reset did not end with a strap latch");
   a_wake_only: assert property (
      @(posedge core_clk) disable iff (!arst_n)
      s_wake_wr |=> !power_down && !soft_reset && $stable(loopback))
      else $error("first reset write did more than wake");
   a_restart_pulse: assert property (
      @(posedge core_clk) disable iff (!arst_n)
      state == st_run && ctrl_wr && mgmt_wdata[BIT_AN_RESTART]
         && !mgmt_wdata[BIT_RESET]
      |=> an_restart && !ctrl[BIT_AN_RESTART])
      else $error("autoneg restart not raised");
   // back-to-back restart writes may legally hold the pulse up longer
   a_restart_cause: assert property (
      @(posedge core_clk) disable iff (!arst_n)
      an_restart |-> $past(ctrl_wr && mgmt_wdata[BIT_AN_RESTART]))
      else $error("autoneg restart without a restart write");
   a_duplex_strap: assert property (
      @(posedge core_clk) disable iff (!arst_n)
      state == st_strap |=> ctrl[BIT_DUPLEX] == !$past(duplex_strap))
      else $error("duplex default not inverse of strap");
   a_straps_latch: assert property (
      @(posedge core_clk) disable iff (!arst_n)
      state == st_strap |=> an_enable == $past(autoneg_enable_strap)
         && isolate == $past(isolate_strap))
      else $error("strap defaults not latched");
   a_reserved_zero: assert property (
      @(posedge core_clk) disable iff (!arst_n)
      sel_ctrl |-> (mgmt_rdata & RESERVED_MASK) == ZERO_WORD)
      else $error("reserved bits read nonzero");
   a_forced_speed: assert property (
      @(posedge core_clk) disable iff (!arst_n)
      !an_enable && state == st_run |-> speed_100 == ctrl[BIT_SPEED])
      else $error("forced speed not applied");
   a_an_override: assert property (
      @(posedge core_clk) disable iff (!arst_n)
      an_enable && $past(an_done) && state == st_run
         && $past(state) == st_run && $stable(ctrl)
      |-> full_duplex == $past(an_full_duplex))
      else $error("autoneg result not used");
   a_plain_bits: assert property (
      @(posedge core_clk) disable iff (!arst_n)
      state == st_run && ctrl_wr && !mgmt_wdata[BIT_RESET]
      |=> loopback == $past(mgmt_wdata[BIT_LOOPBACK])
         && col_test == $past(mgmt_wdata[BIT_COL_TEST])
         && power_down == $past(mgmt_wdata[BIT_PDOWN]))
      else $error("control bit write not stored");
endmodule

// file: sim/phy_mgmt_master.sv
/*
 management master model: one-cycle write strobes, held-address reads.
 assumes the block samples its inputs on the rising edge of core_clk.
*/
`timescale 1ns/1ps
module phy_mgmt_master
   import phy_ctrl_pkg::*;
(
   // clock
   input wire logic core_clk,
   // management access
   output logic mgmt_wr,
   output logic [ADDR_W-1:0] mgmt_addr,
   output logic [DATA_W-1:0] mgmt_wdata,
   input wire logic [DATA_W-1:0] mgmt_rdata
);
   logic [DATA_W-1:0] rd_data;
   event rd_ev;
   ////////////////////////////////////////////////////////////////////////
   // idle until the bench asks for an access
   initial
   begin
      mgmt_wr = 1'b0;
      mgmt_addr = 5'h00;
      mgmt_wdata = 16'h0000;
   end
   // stale data is inverted so a late sample cannot pass by luck
   task automatic wr_word(input logic [ADDR_W-1:0] a,
                          input logic [DATA_W-1:0] d);
      @(negedge core_clk);
      mgmt_addr <= a;
      mgmt_wdata <= d;
      mgmt_wr <= 1'b1;
      @(negedge core_clk);
      mgmt_wr <= 1'b0;
      mgmt_wdata <= ~d;
   endtask
   // read data is registered, so two falling edges give margin
   task automatic rd_word(input logic [ADDR_W-1:0] a);
      @(negedge core_clk);
      mgmt_addr <= a;
      repeat (2) @(negedge core_clk);
      rd_data = mgmt_rdata;
      -> rd_ev;
   endtask
endmodule

// file: sim/phy_basic_control_tb_top.sv
/*
 self-checking bench for the basic control register block.
 assumes the management master model drives the access ports.
*/
`timescale 1ns/1ps
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin err_count++; \
   $display("BAD t=%0t got=%h exp=%h", $time, (g), (e)); end end
module phy_basic_control_tb_top;
   import phy_ctrl_pkg::*;
   logic core_clk, arst_n, mgmt_wr;
   logic [ADDR_W-1:0] mgmt_addr;
   logic [DATA_W-1:0] mgmt_wdata, mgmt_rdata, obs_v, r;
   logic [DATA_W-1:0] exp_q[$];
   logic [DATA_W-1:0] mem [32];
   logic [3:0] strap;
   logic an_done, an_speed_100, an_full_duplex;
   logic soft_reset, loopback, power_down, isolate, an_enable;
   logic an_restart, speed_100, full_duplex, col_test;
   logic [8:0] ctrl_vec;
   int err_count, n_checks, n_rst, n_rs, cycles;
   event obs_ev;
   assign ctrl_vec = {soft_reset, loopback, power_down, isolate, an_enable,
                      an_restart, speed_100, full_duplex, col_test};
   ////////////////////////////////////////////////////////////////////////
   // 8 ns clock
   initial
   begin
      core_clk = 1'b0;
      forever #4 core_clk = ~core_clk;
   end
   phy_mgmt_master mm_u (.core_clk(core_clk), .mgmt_wr(mgmt_wr),
      .mgmt_addr(mgmt_addr), .mgmt_wdata(mgmt_wdata),
      .mgmt_rdata(mgmt_rdata));
   phy_basic_control dut_u (.core_clk(core_clk), .arst_n(arst_n),
      .mgmt_wr(mgmt_wr), .mgmt_addr(mgmt_addr), .mgmt_wdata(mgmt_wdata),
      .mgmt_rdata(mgmt_rdata), .autoneg_enable_strap(strap[3]),
      .isolate_strap(strap[2]), .speed_strap(strap[1]),
      .duplex_strap(strap[0]), .an_done(an_done),
      .an_speed_100(an_speed_100), .an_full_duplex(an_full_duplex),
      .soft_reset(soft_reset), .loopback(loopback),
      .power_down(power_down), .isolate(isolate), .an_enable(an_enable),
      .an_restart(an_restart), .speed_100(speed_100),
      .full_duplex(full_duplex), .col_test(col_test));
   ////////////////////////////////////////////////////////////////////////
   // strap defaults of register 0, straps as {an, iso, speed, duplex}
   function automatic logic [DATA_W-1:0] dflt(input logic [3:0] s);
      dflt = {2'b00, s[1], s[3], 1'b0, s[2], 1'b0, ~s[0], 8'h00};
   endfunction
   task automatic rd_exp(input logic [ADDR_W-1:0] a,
                         input logic [DATA_W-1:0] e);
      exp_q.push_back(e);
      mm_u.rd_word(a);
   endtask
   // waiting a falling edge keeps the next note from overwriting this one
   // and keeps the stimulus that follows on the falling edge
   task automatic note(input logic [DATA_W-1:0] g,
                       input logic [DATA_W-1:0] e);
      exp_q.push_back(e);
      obs_v = g;
      -> obs_ev;
      @(negedge core_clk);
   endtask
   task automatic count(input int n);
      n_rst = 0;
      n_rs = 0;
      // first sample is the edge the write task returns on, where a
      // one-cycle pulse already stands
      repeat (n)
      begin
         if (soft_reset === 1'b1) n_rst++;
         if (an_restart === 1'b1) n_rs++;
         @(negedge core_clk);
      end
   endtask
   task automatic check(input logic [DATA_W-1:0] g);
      logic [DATA_W-1:0] e;
      e = exp_q.pop_front();
      `CHK(g, e)
   endtask
   task automatic final_report;
      $display("checks=%0d mismatches=%0d", n_checks, err_count);
      if (err_count == 0 && n_checks > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////////
   // results are taken off the queue as they appear
   always @(mm_u.rd_ev) check(mm_u.rd_data);
   always @(obs_ev) check(obs_v);
   // a hang is cut short well past the expected few hundred cycles
   always @(posedge core_clk)
   begin
      cycles++;
      if (cycles == 3000)
      begin
         err_count++;
         final_report();
      end
   end
   ////////////////////////////////////////////////////////////////////////
   // main sequence
   initial
   begin
      err_count = 0;
      n_checks = 0;
      cycles = 0;
      arst_n = 1'b0;
      an_done = 1'b0;
      an_speed_100 = 1'b0;
      an_full_duplex = 1'b0;
      void'($urandom(77));
      strap = 4'($urandom());
      repeat (6) @(negedge core_clk);
      arst_n = 1'b1;
      repeat (3) @(negedge core_clk);
      rd_exp(REG_BASIC_CONTROL, dflt(strap));
      note({7'h00, ctrl_vec}, {10'h000, strap[2], strap[3], 1'b0,
           strap[1], ~strap[0], 1'b0});
      $display("test 1 done");
      mm_u.wr_word(REG_BASIC_CONTROL, 16'h65ff);
      rd_exp(REG_BASIC_CONTROL, 16'h6580);
      note({7'h00, ctrl_vec}, 16'h00a7);
      r = 16'($urandom());
      an_done = 1'b1;
      an_speed_100 = r[0];
      an_full_duplex = r[1];
      mm_u.wr_word(REG_BASIC_CONTROL, 16'h3100);
      rd_exp(REG_BASIC_CONTROL, 16'h3100);
      note({7'h00, ctrl_vec}, {11'h000, 1'b1, 1'b0, r[0], r[1],
           1'b0});
      $display("test 2 done");
      mm_u.wr_word(REG_BASIC_CONTROL, 16'h3300);
      count(6);
      note(16'(n_rs), 16'h0001);
      rd_exp(REG_BASIC_CONTROL, 16'h3100);
      $display("test 3 done");
      for (int a = 1; a < 32; a++)
      begin
         mem[a] = 16'($urandom());
         mm_u.wr_word(5'(a), mem[a]);
      end
      for (int a = 1; a < 32; a++) rd_exp(5'(a), mem[a]);
      rd_exp(REG_BASIC_CONTROL, 16'h3100);
      $display("test 4 done");
      mm_u.wr_word(REG_BASIC_CONTROL, 16'h3900);
      rd_exp(REG_BASIC_CONTROL, 16'h3900);
      strap = 4'($urandom());
      mm_u.wr_word(REG_BASIC_CONTROL, 16'hc000);
      count(16);
      note(16'(n_rst), 16'h0000);
      rd_exp(REG_BASIC_CONTROL, 16'h3100);
      mm_u.wr_word(REG_BASIC_CONTROL, 16'h8000);
      count(20);
      note(16'(n_rst >= RESET_PULSE_CYC && n_rst <= RESET_PULSE_CYC + 2),
           16'h0001);
      rd_exp(REG_BASIC_CONTROL, dflt(strap));
      rd_exp(VENDOR_FIRST, 16'h0000);
      $display("test 5 done");
      // async reset in mid-run: soft_reset rises and the other controls drop at once, straps relatch
      mm_u.wr_word(VENDOR_FIRST, 16'h5a5a);
      strap = 4'($urandom());
      arst_n = 1'b0;
      @(negedge core_clk);
      note({7'h00, ctrl_vec}, 16'h0100);
      arst_n = 1'b1;
      repeat (2) @(negedge core_clk);
      rd_exp(REG_BASIC_CONTROL, dflt(strap));
      rd_exp(VENDOR_FIRST, 16'h0000);
      $display("test 6 done");
      final_report();
   end
endmodule
